// *** logic/serial_cfg_map.svh ***
// register offsets, field positions, codes and reset values of the serial format block
`ifndef SERIAL_CFG_MAP_SVH
`define SERIAL_CFG_MAP_SVH

// ------------------------------------------------------------
// register byte offsets
// ------------------------------------------------------------
`define OFS_MODE 12'h000
`define OFS_CTRL0 12'h004
`define OFS_BRG 12'h008
`define OFS_CTRL1 12'h00C
`define OFS_TXBUF 12'h010
`define OFS_RXBUF 12'h014
`define OFS_STAT 12'h018

// ------------------------------------------------------------
// mode register fields
// ------------------------------------------------------------
`define MODE_FMT_HI 2
`define MODE_CLK_EXT 3
`define MODE_TWO_STOP 4
`define MODE_PAR_EVEN 5
`define MODE_PAR_EN 6
`define MODE_SLEEP 7
`define FMT_SYNC 3'h1
`define FMT_ASYNC7 3'h4
`define FMT_ASYNC8 3'h5
`define FMT_ASYNC9 3'h6

// ------------------------------------------------------------
// control register 0 and 1 fields
// ------------------------------------------------------------
`define CTRL0_CS_HI 1
`define CTRL0_FLOW_RTS 2
`define CTRL0_FLOW_OFF 4
`define CTRL0_MSB_FIRST 7
`define CTRL1_TE 0
`define CTRL1_RE 2

// ------------------------------------------------------------
// reset values and divider constants
// ------------------------------------------------------------
`define MODE_RST 8'h00
`define CTRL0_RST 8'h00
`define BRG_RST 8'h00
`define PHASE_LAST 4'hF
`define CNT_ZERO 8'h00
`define PHASE_ZERO 4'h0

`endif

// *** logic/serial_cfg_pkg.sv ***
// types shared by the serial format and configuration block
package serial_cfg_pkg;

    // ------------------------------------------------------------
    // bus carriers
    // ------------------------------------------------------------
    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [11:0] paddr;
        logic [31:0] pwdata;
    } apb_req_s;

    typedef struct packed {
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
    } apb_rsp_s;

    // ------------------------------------------------------------
    // frame format
    // ------------------------------------------------------------
    typedef enum logic [1:0] {LEN_NONE, LEN_7, LEN_8, LEN_9} data_len_e;

    typedef struct packed {
        data_len_e len;
        logic sync_mode;
        logic two_stop;
        logic parity_en;
        logic parity_even;
        logic sleep_sel;
        logic msb_first;
    } frame_cfg_s;

    // ------------------------------------------------------------
    // module state
    // ------------------------------------------------------------
    typedef struct packed {
        logic [7:0] cnt;
        logic [3:0] phase;
        logic x16_tick;
        logic bit_tick;
    } div_state_s;

    typedef struct packed {
        logic [7:0] mode;
        logic [7:0] ctrl0;
        logic [7:0] brg;
        logic te;
        logic re;
        logic ti;
        logic tx_active;
        logic rx_busy;
        logic rx_full;
        logic [8:0] txbuf;
        logic [8:0] rxbuf;
        logic ext_prev;
        logic tx_start;
        logic [8:0] tx_data;
        logic parity_bit;
        frame_cfg_s cfg;
        logic rts;
        logic flow_oe;
        logic flow_port;
        logic clk_port;
        apb_rsp_s rsp;
    } top_state_s;

endpackage

// *** logic/bit_order_swap.sv ***
// bus-to-buffer bit order mapping, straight or reversed
`timescale 1ns/1ps
`default_nettype none

module bit_order_swap (
    // data
    input wire logic [7:0] din,
    output logic [7:0] dout,
    // order
    input wire logic reverse
);

    genvar i;
    generate
        for (i = 0; i < 8; i = i + 1) begin : g_bit
            assign dout[i] = reverse ? din[7 - i] : din[i];
        end
    endgenerate

endmodule

`default_nettype wire

// *** logic/baud_divider.sv ***
// (n+1) prescale followed by divide-by-16 bit clock, restartable
`timescale 1ns/1ps
`default_nettype none
`include "serial_cfg_map.svh"

module baud_divider (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // control
    input wire logic src_tick,
    input wire logic restart,
    input wire logic [7:0] divisor,
    // ticks
    output logic x16_tick,
    output logic bit_tick
);
    import serial_cfg_pkg::*;

    div_state_s q;
    div_state_s d;

    // ------------------------------------------------------------
    // divider
    // ------------------------------------------------------------
    always_comb begin
        d = q;
        d.x16_tick = 1'b0;
        d.bit_tick = 1'b0;
        if (restart) begin
            d.cnt = `CNT_ZERO;
            d.phase = `PHASE_ZERO;
        end else if (src_tick) begin
            if (q.cnt >= divisor) begin
                d.cnt = `CNT_ZERO;
                d.x16_tick = 1'b1;
                d.phase = q.phase + 4'h1;
                if (q.phase == `PHASE_LAST) begin
                    d.bit_tick = 1'b1;
                end
            end else begin
                d.cnt = q.cnt + 8'h01;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign x16_tick = q.x16_tick;
    assign bit_tick = q.bit_tick;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    chk_restart_align: assert property (@(posedge pclk) disable iff (!presetn)
        restart |=> (q.cnt == `CNT_ZERO) && (q.phase == `PHASE_ZERO) && !q.bit_tick)
        else $error("divider not realigned by start bit");

    chk_bit_after_sixteen: assert property (@(posedge pclk) disable iff (!presetn)
        q.bit_tick |-> q.x16_tick && ($past(q.phase) == `PHASE_LAST)
            && ($past(q.cnt) >= $past(divisor)) && $past(src_tick))
        else $error("bit tick not on sixteenth prescaled tick");

endmodule

`default_nettype wire

// *** logic/serial_frame_cfg.sv ***
// serial port format, bit order, baud divider and flow control setup with apb registers
//
// Functional notes
// - in synchronous mode control 0 bit 7 picks lsb-first (0) or msb-first (1).
// - msb-first reverses bus bits 7..0 onto buffer bits 0..7 for tx writes and rx reads.
// - the shifter sees the same buffer either way; only the bus mapping changes.
// - asynchronous frames carry seven, eight or nine data bits, same sequence for each.
// - mode bits 2..0 equal to 1,0,1 select eight-bit asynchronous operation.
// - mode bit 3 picks internal clock (0) or external serial clock pin (1).
// - with internal clock, control 0 bits 1..0 pick the prescaled source.
// - asynchronous with internal clock frees the serial clock pin for general use.
// - the selected clock is divided by n+1 and then by sixteen for the bit clock.
// - mode bit 4 picks one or two stop bits.
// - mode bit 5 picks odd or even parity over data plus parity bit.
// - mode bit 6 enables parity insertion and checking.
// - mode bit 7 is the receiver sleep select.
// - control 0 bit 2 makes the flow pin clear-to-send in (0) or request-to-send out (1).
// - control 0 bit 4 high drops flow control and returns the pin to port use.
// - with clear-to-send, start needs transmit enabled, buffer full and input low.
// - request-to-send goes low when receive is enabled, high once reception starts.
//
// Local design decisions: register access over APB and the address map.
`timescale 1ns/1ps
`default_nettype none
`include "serial_cfg_map.svh"

module serial_frame_cfg (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb
    input wire serial_cfg_pkg::apb_req_s apb_req,
    output serial_cfg_pkg::apb_rsp_s apb_rsp,
    // clock sources
    input wire logic [3:0] presc_tick,
    input wire logic external_serial_clock,
    // flow control and serial clock pins
    input wire logic clear_to_send_in,
    output logic request_to_send_out,
    output logic flow_pin_oe,
    output logic flow_pin_is_port,
    output logic serial_clock_pin_is_port,
    // transmit shifter side
    input wire logic tx_done,
    output logic tx_start,
    output logic [8:0] tx_shift_data,
    output logic parity_bit,
    // receive shifter side
    input wire logic rx_start_detect,
    input wire logic rx_load,
    input wire logic [8:0] rx_word,
    // format and timing
    output serial_cfg_pkg::frame_cfg_s frame_cfg,
    output logic sample_tick,
    output logic bit_tick
);
    import serial_cfg_pkg::*;

    top_state_s q;
    top_state_s d;
    logic setup;
    logic done;
    logic msb_eff;
    logic src_tick;
    logic cts_ok;
    logic wr_tx;
    logic [11:0] addr;
    logic [7:0] tx_bus_in;
    logic [7:0] rx_bus_out;
    logic [8:0] par_mask;

    // ------------------------------------------------------------
    // shared decode
    // ------------------------------------------------------------
    assign addr = apb_req.paddr;
    assign setup = apb_req.psel && !apb_req.penable;
    assign done = apb_req.psel && apb_req.penable && q.rsp.pready;
    assign wr_tx = done && apb_req.pwrite && (addr == `OFS_TXBUF);
    // order bit only in synchronous mode
    assign msb_eff = (q.mode[`MODE_FMT_HI:0] == `FMT_SYNC) && q.ctrl0[`CTRL0_MSB_FIRST];

    // ------------------------------------------------------------
    // bit order mapping
    // ------------------------------------------------------------
    // write path reversal
    bit_order_swap u_tx_swap (
        .din(apb_req.pwdata[7:0]),
        .dout(tx_bus_in),
        .reverse(msb_eff)
    );

    bit_order_swap u_rx_swap (
        .din(q.rxbuf[7:0]),
        .dout(rx_bus_out),
        .reverse(msb_eff)
    );

    // ------------------------------------------------------------
    // clock source and divider
    // ------------------------------------------------------------
    always_comb begin
        // external pin edge or internal prescaler
        if (q.mode[`MODE_CLK_EXT]) begin
            src_tick = external_serial_clock && !q.ext_prev;
        end else begin
            src_tick = presc_tick[q.ctrl0[`CTRL0_CS_HI:0]];
        end
    end

    baud_divider u_div (
        .pclk(pclk),
        .presetn(presetn),
        .src_tick(src_tick),
        .restart(rx_start_detect),
        .divisor(q.brg),
        .x16_tick(sample_tick),
        .bit_tick(bit_tick)
    );

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    // clear-to-send gating
    assign cts_ok = q.ctrl0[`CTRL0_FLOW_OFF] || q.ctrl0[`CTRL0_FLOW_RTS] || !clear_to_send_in;

    always_comb begin
        d = q;
        d.ext_prev = external_serial_clock;
        d.tx_start = 1'b0;
        d.rsp.pready = 1'b0;
        d.rsp.pslverr = 1'b0;
        par_mask = 9'h0FF;
        // apb setup: prepare answer
        if (setup) begin
            d.rsp.pready = 1'b1;
            d.rsp.prdata = '0;
            if (addr == `OFS_MODE) begin
                d.rsp.prdata[7:0] = q.mode;
            end else if (addr == `OFS_CTRL0) begin
                d.rsp.prdata[7:0] = q.ctrl0;
            end else if (addr == `OFS_BRG) begin
                d.rsp.prdata[7:0] = q.brg;
            end else if (addr == `OFS_CTRL1) begin
                d.rsp.prdata[`CTRL1_TE] = q.te;
                d.rsp.prdata[`CTRL1_RE] = q.re;
            end else if (addr == `OFS_TXBUF) begin
                d.rsp.prdata[8:0] = q.txbuf;
            end else if (addr == `OFS_RXBUF) begin
                d.rsp.prdata[8:0] = {q.rxbuf[8], rx_bus_out};
            end else if (addr == `OFS_STAT) begin
                d.rsp.prdata[4:0] = {q.rts, q.rx_busy, q.rx_full, q.tx_active, q.ti};
            end else begin
                d.rsp.pslverr = 1'b1;
            end
        end
        // apb access: writes take effect
        if (done && apb_req.pwrite) begin
            if (addr == `OFS_MODE) begin
                d.mode = apb_req.pwdata[7:0];
            end else if (addr == `OFS_CTRL0) begin
                d.ctrl0 = apb_req.pwdata[7:0];
            end else if (addr == `OFS_BRG) begin
                d.brg = apb_req.pwdata[7:0];
            end else if (addr == `OFS_CTRL1) begin
                d.te = apb_req.pwdata[`CTRL1_TE];
                d.re = apb_req.pwdata[`CTRL1_RE];
                if (!apb_req.pwdata[`CTRL1_RE]) begin
                    d.rx_full = 1'b0;
                    d.rx_busy = 1'b0;
                end
            end else if (addr == `OFS_TXBUF) begin
                // buffer loaded through the order mapping
                d.txbuf = {apb_req.pwdata[8], tx_bus_in};
                d.ti = 1'b0;
            end
        end
        // reading the receive buffer empties it
        if (done && !apb_req.pwrite && (addr == `OFS_RXBUF)) begin
            d.rx_full = 1'b0;
        end
        // transmit start, not in the cycle a new word is written
        if (tx_done) begin
            d.tx_active = 1'b0;
        end
        if (q.te && !q.ti && !q.tx_active && cts_ok && !wr_tx) begin
            d.tx_start = 1'b1;
            d.tx_active = 1'b1;
            d.ti = 1'b1;
            d.tx_data = q.txbuf;
        end
        // receive side, hardware set wins over clear
        if (rx_start_detect && q.re) begin
            d.rx_busy = 1'b1;
        end
        if (rx_load && q.re) begin
            d.rx_busy = 1'b0;
            d.rx_full = 1'b1;
            d.rxbuf = rx_word;
        end
        case (q.mode[`MODE_FMT_HI:0])
            `FMT_ASYNC7: begin
                d.cfg.len = LEN_7;
                par_mask = 9'h07F;
            end
            `FMT_ASYNC8: begin
                d.cfg.len = LEN_8;
            end
            `FMT_ASYNC9: begin
                d.cfg.len = LEN_9;
                par_mask = 9'h1FF;
            end
            default: begin
                d.cfg.len = LEN_NONE;
            end
        endcase
        d.cfg.sync_mode = (q.mode[`MODE_FMT_HI:0] == `FMT_SYNC);
        d.cfg.two_stop = q.mode[`MODE_TWO_STOP];
        d.cfg.parity_en = q.mode[`MODE_PAR_EN];
        d.cfg.parity_even = q.mode[`MODE_PAR_EVEN];
        d.cfg.sleep_sel = q.mode[`MODE_SLEEP];
        d.cfg.msb_first = msb_eff;
        if (q.te && !q.ti && !q.tx_active && cts_ok && !wr_tx) begin
            d.parity_bit = q.mode[`MODE_PAR_EVEN] ? ^(q.txbuf & par_mask)
                : ~^(q.txbuf & par_mask);
        end
        // flow control off frees the pin
        d.flow_port = q.ctrl0[`CTRL0_FLOW_OFF];
        d.flow_oe = !q.ctrl0[`CTRL0_FLOW_OFF] && q.ctrl0[`CTRL0_FLOW_RTS];
        // ready low while enabled and idle
        d.rts = !(q.re && !q.rx_busy && !(rx_start_detect));
        d.clk_port = (d.cfg.len != LEN_NONE) && !q.mode[`MODE_CLK_EXT];
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            q <= '0;
            q.mode <= `MODE_RST;
            q.ctrl0 <= `CTRL0_RST;
            q.brg <= `BRG_RST;
            q.ti <= 1'b1;
            q.rts <= 1'b1;
        end else begin
            q <= d;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign apb_rsp = q.rsp;
    assign request_to_send_out = q.rts;
    assign flow_pin_oe = q.flow_oe;
    assign flow_pin_is_port = q.flow_port;
    assign serial_clock_pin_is_port = q.clk_port;
    assign tx_start = q.tx_start;
    assign tx_shift_data = q.tx_data;
    assign parity_bit = q.parity_bit;
    assign frame_cfg = q.cfg;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence s_rx_read_setup;
        setup && !apb_req.pwrite && (addr == `OFS_RXBUF);
    endsequence

    chk_msb_read_swap: assert property (s_rx_read_setup and msb_eff |=>
        (apb_rsp.prdata[0] == $past(q.rxbuf[7])) && (apb_rsp.prdata[7] == $past(q.rxbuf[0])))
        else $error("msb-first read not reversed");

    chk_lsb_read_straight: assert property (s_rx_read_setup and !msb_eff |=>
        apb_rsp.prdata[7:0] == $past(q.rxbuf[7:0]))
        else $error("lsb-first read altered");

    chk_msb_write_swap: assert property (wr_tx && msb_eff |=>
        (q.txbuf[7] == $past(apb_req.pwdata[0])) && (q.txbuf[0] == $past(apb_req.pwdata[7])))
        else $error("msb-first write not reversed");

    chk_cts_start_gate: assert property (tx_start |->
        $past(q.te) && !$past(q.ti) && $past(cts_ok) ##1 q.ti)
        else $error("transmit started without its condition");

    chk_rts_start_high: assert property (rx_start_detect && q.re && q.ctrl0[`CTRL0_FLOW_RTS]
        |=> request_to_send_out [*2])
        else $error("request-to-send not raised on reception start");

    chk_odd_parity_sum: assert property (tx_start && frame_cfg.parity_en
        && !frame_cfg.parity_even && (frame_cfg.len == LEN_8)
        |-> ^{tx_shift_data[7:0], parity_bit})
        else $error("odd parity sum not odd");

    chk_flow_off_port: assert property (q.ctrl0[`CTRL0_FLOW_OFF] |=>
        flow_pin_is_port && !flow_pin_oe)
        else $error("flow pin not released");

    chk_len8_decode: assert property ((q.mode[`MODE_FMT_HI:0] == `FMT_ASYNC8)
        && !apb_req.psel |=> (frame_cfg.len == LEN_8) ##1 (frame_cfg.len == LEN_8))
        else $error("eight-bit format not decoded");

    chk_clk_pin_release: assert property (q.mode[`MODE_CLK_EXT] |=>
        !serial_clock_pin_is_port)
        else $error("clock pin released with external clock");

endmodule

`default_nettype wire

// *** sim/peer_serial.sv ***
// peer serial device model: flow input, frame completion and receive events
`timescale 1ns/1ps
`default_nettype none

module peer_serial (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // bench commands
    input wire logic hold_off,
    input wire logic rx_go,
    input wire logic [8:0] rx_data,
    input wire logic ext_run,
    // device side
    input wire logic tx_start,
    output logic clear_to_send_in,
    output logic external_serial_clock,
    output logic tx_done,
    output logic rx_start_detect,
    output logic rx_load,
    output logic [8:0] rx_word
);
    // peer frame length is a fixed FRAME_CYC of 20 cycles whatever the programmed format
    localparam int FRAME_CYC = 20;
    int tx_cnt;
    int rx_cnt;
    logic [1:0] ext_div;

    // external clock runs at a quarter rate only while asked, else stands low
    assign external_serial_clock = ext_div[1];
    // peer permits or holds off our transmit start
    assign clear_to_send_in = hold_off;

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tx_cnt <= 0;
            rx_cnt <= 0;
            tx_done <= 1'b0;
            rx_start_detect <= 1'b0;
            rx_load <= 1'b0;
            rx_word <= 9'h000;
            ext_div <= 2'h0;
        end else begin
            ext_div <= ext_run ? ext_div + 2'h1 : 2'h0;
            tx_done <= (tx_cnt == 1);
            if (tx_start)
                tx_cnt <= FRAME_CYC;
            else if (tx_cnt != 0)
                tx_cnt <= tx_cnt - 1;
            rx_start_detect <= rx_go;
            rx_load <= (rx_cnt == 1);
            if (rx_go)
                rx_cnt <= 5;
            else if (rx_cnt != 0)
                rx_cnt <= rx_cnt - 1;
            // idle data shows the inverse of its last value
            rx_word <= (rx_cnt == 1) ? rx_data : ~rx_word;
        end
    end
endmodule
`default_nettype wire

// *** sim/serial_frame_cfg_test.sv ***
// self-checking bench of the serial format and configuration block
`timescale 1ns/1ps
`default_nettype none
`include "serial_cfg_map.svh"

module serial_frame_cfg_test;
    import serial_cfg_pkg::*;
    logic pclk, presetn, hold_off, rx_go, sel, ext_run;
    logic [8:0] rx_data;
    logic [3:0] presc_tick;
    apb_req_s req;
    apb_rsp_s rsp;
    frame_cfg_s fcfg;
    logic cts, ext_clk, rts, oe, fport, cport, tx_done, tx_start, par, rxs, rxl;
    logic sample_tick, bit_tick, pick;
    logic [8:0] txd, rxw;
    logic [31:0] rdat;
    logic rerr;
    int miscompares, total_checks, cyc, starts;

    assign pick = sel ? sample_tick : bit_tick;

    serial_frame_cfg i_dut (.pclk(pclk), .presetn(presetn), .apb_req(req), .apb_rsp(rsp),
        .presc_tick(presc_tick), .external_serial_clock(ext_clk), .clear_to_send_in(cts),
        .request_to_send_out(rts), .flow_pin_oe(oe), .flow_pin_is_port(fport),
        .serial_clock_pin_is_port(cport), .tx_done(tx_done), .tx_start(tx_start),
        .tx_shift_data(txd), .parity_bit(par), .rx_start_detect(rxs), .rx_load(rxl),
        .rx_word(rxw), .frame_cfg(fcfg), .sample_tick(sample_tick), .bit_tick(bit_tick));

    peer_serial i_peer (.pclk(pclk), .presetn(presetn), .hold_off(hold_off), .rx_go(rx_go),
        .rx_data(rx_data), .ext_run(ext_run), .tx_start(tx_start), .clear_to_send_in(cts),
        .external_serial_clock(ext_clk), .tx_done(tx_done), .rx_start_detect(rxs),
        .rx_load(rxl), .rx_word(rxw));

    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end

    always @(posedge pclk) begin
        cyc++;
        if (tx_start === 1'b1)
            starts++;
        if (cyc > 20000) begin
            miscompares++;
            wrap_up();
        end
    end

    task automatic wrap_up();
        if (miscompares == 0 && total_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        total_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        req <= '{1'b1, 1'b0, w, a, d};
        @(posedge pclk);
        req.penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (rsp.pready !== 1'b1);
        rdat = rsp.prdata;
        rerr = rsp.pslverr;
        req.psel <= 1'b0;
        req.penable <= 1'b0;
        @(posedge pclk);
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
        @(posedge pclk);
    endtask

    task automatic rd(input string what, input logic [11:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(what, exp, rdat);
    endtask

    task automatic wait_on(output int n);
        n = 0;
        while (pick !== 1'b1 && n < 300) begin
            @(posedge pclk);
            n++;
        end
    endtask

    task automatic t_reset();
        rd("mode", `OFS_MODE, 32'h0);
        rd("ctrl0", `OFS_CTRL0, 32'h0);
        rd("stat", `OFS_STAT, 32'h11);
        rd("unmapped", 12'h01C, 32'h0);
        chk("unmapped err", 1, rerr);
    endtask

    task automatic t_format();
        logic [2:0] codes [4] = '{3'h4, 3'h5, 3'h6, 3'h0};
        data_len_e lens [4] = '{LEN_7, LEN_8, LEN_9, LEN_NONE};
        for (int i = 0; i < 4; i++) begin
            wr(`OFS_MODE, {29'h0, codes[i]});
            chk("len", lens[i], fcfg.len);
            wr(`OFS_MODE, 32'h05 | (32'h10 << i));
            chk("fields", 4'h8 >> i, {fcfg.two_stop, fcfg.parity_even, fcfg.parity_en,
                fcfg.sleep_sel});
        end
        chk("clk port", 1, cport);
        wr(`OFS_MODE, 32'h0D);
        chk("clk ext", 0, cport);
        wr(`OFS_MODE, 32'h01);
        chk("sync", 1, fcfg.sync_mode);
    endtask

    task automatic t_tx(input logic [7:0] m, input logic [7:0] c, input logic [8:0] d,
            input logic [8:0] e, input logic p, input logic pc);
        int n;
        wr(`OFS_MODE, {24'h0, m});
        wr(`OFS_CTRL0, {24'h0, c});
        wr(`OFS_CTRL1, 32'h1);
        apb(1'b1, `OFS_TXBUF, {23'h0, d});
        sel = 1'b0;
        n = 0;
        while (tx_start !== 1'b1 && n < 50) begin
            @(posedge pclk);
            n++;
        end
        chk("started", 1, n < 50);
        chk("tx data", e, txd);
        if (pc)
            chk("parity", p, par);
        repeat (25) @(posedge pclk);
    endtask

    task automatic t_cts();
        int s0, n;
        wr(`OFS_CTRL0, 32'h0);
        hold_off <= 1'b1;
        s0 = starts;
        apb(1'b1, `OFS_TXBUF, 32'h55);
        repeat (10) @(posedge pclk);
        chk("held", s0, starts);
        chk("port", 0, {oe, fport});
        hold_off <= 1'b0;
        repeat (10) @(posedge pclk);
        chk("released", s0 + 1, starts);
        repeat (25) @(posedge pclk);
        wr(`OFS_CTRL0, 32'h10);
        chk("flow off", 1, fport);
    endtask

    task automatic t_rts();
        wr(`OFS_CTRL1, 32'h0);
        wr(`OFS_MODE, 32'h01);
        wr(`OFS_CTRL0, 32'h84);
        chk("rts idle", 2'b11, {rts, oe});
        chk("msb cfg", 1, fcfg.msb_first);
        wr(`OFS_CTRL1, 32'h4);
        chk("rts ready", 0, rts);
        rx_data <= 9'h12D;
        rx_go <= 1'b1;
        @(posedge pclk);
        rx_go <= 1'b0;
        repeat (2) @(posedge pclk);
        chk("rts busy", 1, rts);
        repeat (8) @(posedge pclk);
        chk("rts again", 0, rts);
        rd("rxbuf", `OFS_RXBUF, 32'h1B4);
        wr(`OFS_CTRL0, 32'h04);
        rd("rxbuf lsb", `OFS_RXBUF, 32'h12D);
    endtask

    task automatic t_div();
        int n;
        wr(`OFS_MODE, 32'h05);
        wr(`OFS_BRG, 32'h2);
        wr(`OFS_CTRL0, 32'h11);
        for (int s = 0; s < 2; s++) begin
            sel = s[0];
            wait_on(n);
            @(posedge pclk);
            wait_on(n);
            chk("tick gap", s ? 2 : 47, n);
        end
        wr(`OFS_CTRL0, 32'h10);
        @(posedge pclk);
        wait_on(n);
        chk("no source", 300, n);
        wr(`OFS_MODE, 32'h0D);
        wr(`OFS_BRG, 32'h0);
        ext_run <= 1'b1;
        wait_on(n);
        @(posedge pclk);
        wait_on(n);
        chk("ext gap", 3, n);
        ext_run <= 1'b0;
    endtask

    initial begin
        presetn = 1'b0;
        req = '0;
        presc_tick = 4'h2;
        hold_off = 1'b0;
        rx_go = 1'b0;
        ext_run = 1'b0;
        rx_data = 9'h0;
        sel = 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        t_reset();
        t_format();
        t_tx(8'h01, 8'h10, 9'h02D, 9'h02D, 1'b0, 1'b0);
        t_tx(8'h01, 8'h90, 9'h12D, 9'h1B4, 1'b0, 1'b0);
        t_tx(8'h45, 8'h90, 9'h02D, 9'h02D, 1'b1, 1'b1);
        t_tx(8'h65, 8'h10, 9'h02D, 9'h02D, 1'b0, 1'b1);
        t_tx(8'h64, 8'h10, 9'h0AD, 9'h0AD, 1'b0, 1'b1);
        t_cts();
        t_rts();
        t_div();
        wrap_up();
    end
endmodule
`default_nettype wire
